/* File: src/i2sap_port.sv */
// Purpose: stereo serial audio port, clock master or slave, 16-bit words
// Assumes: pin inputs are synchronous to CLOCK; mode and divider held steady
// Notes: transmit words enter through a 4-word fifo, left in [31:16]
// Operation
// RL1: master drives bit clock and word select; slave takes both as inputs.
// RL2: serial data output is an output in both modes.
// RL3: every channel word on the link is sixteen bits.
// RL4: left word msb aligns with the msb slot of the serial bus.
// RL5: word msb appears one bit clock after each word select change.
// RL6: left channel while word select low, right while high.
// RL7: outgoing data bits change on the falling bit clock edge.
// RL8: partner captures device data on the rising bit clock edge.
// RL9: master makes 48 kHz frames of 32 or 50 bit clocks.
// RL10: master bit clock comes from reference by n/m fractional divider.
// RL11: slave accepts any bit clock up to 3.072 MHz.
// RL12: master bit clock keeps fixed mark/space, each phase at least 0.35T.
// RL13: partner's slave clock phases exceed 0.35 receiver_min_clock_period.
// RL14: bit clock period exceeds both transmitter and receiver minimum periods.
// RL15: slots after the sixteen data bits in a half frame drive low.
`timescale 1ns/100ps
`default_nettype none
module i2sap_port (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic MASTER,
	input wire logic LONG_FRAME,
	input wire logic [i2sap_pkg::DIV_W-1:0] DIV_N,
	input wire logic [i2sap_pkg::DIV_W-1:0] DIV_M,
	input wire logic SCK_I,
	output logic SCK_O,
	output logic SCK_OE,
	input wire logic WS_I,
	output logic WS_O,
	output logic WS_OE,
	output logic SDO,
	input wire logic SDI,
	input wire logic TX_VALID,
	output logic TX_READY,
	input wire logic [i2sap_pkg::FIFO_WIDTH-1:0] TX_DATA,
	output logic UNDERRUN,
	output logic RX_VALID,
	output logic RX_RIGHT,
	output logic [i2sap_pkg::WORD_BITS-1:0] RX_DATA
);
	// ==================================================================
	// reset release
	logic [1:0] rst_sync_q;
	wire rst_n = rst_sync_q[1];

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			rst_sync_q <= i2sap_pkg::RST_SYNC_INIT;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	// ==================================================================
	// n/m divider and master bit clock
	logic master_q;
	logic [i2sap_pkg::DIV_W:0] acc_q;
	logic sck_q;
	wire [i2sap_pkg::DIV_W:0] acc_sum = acc_q + {1'b0, DIV_N};
	wire tick = master_q && (acc_sum >= {1'b0, DIV_M});

	always_ff @(posedge CLOCK) begin
		if (!rst_n) begin
			master_q <= 1'b0;
			acc_q <= '0;
			sck_q <= 1'b0;
		end else begin
			master_q <= MASTER;
			acc_q <= tick ? acc_sum - {1'b0, DIV_M} : (master_q ? acc_sum : '0); // RL10
			// toggling on every tick keeps both phases within one clock of each other
			if (tick) begin
				sck_q <= ~sck_q; // RL12
			end
		end
	end

	// ==================================================================
	// edge detection, shared by both modes
	logic sck_in_q;
	logic sck_prev_q;
	logic ws_in_q;
	// pins taken as synchronous, one register is enough to find edges
	wire fall = master_q ? (tick && sck_q) : (sck_prev_q && !sck_in_q); // RL14
	wire rise = master_q ? (tick && !sck_q) : (!sck_prev_q && sck_in_q); // RL11

	always_ff @(posedge CLOCK) begin
		if (!rst_n) begin
			sck_in_q <= 1'b0;
			sck_prev_q <= 1'b0;
			ws_in_q <= 1'b0;
		end else begin
			sck_in_q <= SCK_I;
			sck_prev_q <= sck_in_q;
			ws_in_q <= WS_I;
		end
	end

	// ==================================================================
	// master frame counter and word select
	logic [5:0] fcnt_q;
	logic ws_q;
	wire [5:0] frame_last = LONG_FRAME ? i2sap_pkg::FRAME_LONG_LAST
		: i2sap_pkg::FRAME_SHORT_LAST;
	wire [5:0] half = LONG_FRAME ? i2sap_pkg::HALF_LONG : i2sap_pkg::HALF_SHORT;
	wire [5:0] fcnt_d = (fcnt_q >= frame_last) ? 6'h00 : fcnt_q + 6'h01;
	wire ws_gen = fcnt_d >= half;
	wire ws_new = master_q ? ws_gen : ws_in_q;
	wire trans = fall && (ws_new != ws_q);

	always_ff @(posedge CLOCK) begin
		if (!rst_n) begin
			fcnt_q <= frame_last;
			ws_q <= 1'b1;
		end else if (fall) begin
			if (master_q) begin
				fcnt_q <= fcnt_d; // RL9
			end
			ws_q <= ws_new; // RL6
		end
	end

	// ==================================================================
	// transmit buffer
	logic fifo_valid;
	logic [i2sap_pkg::FIFO_WIDTH-1:0] fifo_data;
	wire load_left = trans && !ws_new;
	wire pop = load_left && fifo_valid;

	i2sap_fifo #(
		.WIDTH(i2sap_pkg::FIFO_WIDTH),
		.DEPTH(i2sap_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(CLOCK),
		.rst_n(rst_n),
		.in_valid(TX_VALID),
		.in_ready(TX_READY),
		.in_data(TX_DATA),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	// ==================================================================
	// transmit shifter
	logic [i2sap_pkg::WORD_BITS-1:0] right_q;
	logic [i2sap_pkg::WORD_BITS-1:0] cur_word_q;
	logic [i2sap_pkg::WORD_BITS-1:0] tx_sh_q;
	logic [4:0] tx_cnt_q;
	logic sdo_q;
	logic underrun_q;
	wire tx_more = tx_cnt_q < i2sap_pkg::TX_CNT_DONE;
	// an empty fifo sends a silent frame rather than stale audio
	wire [i2sap_pkg::WORD_BITS-1:0] left_in = fifo_valid ? fifo_data[31:16] : '0;
	wire [i2sap_pkg::WORD_BITS-1:0] right_in = fifo_valid ? fifo_data[15:0] : '0;
	wire [i2sap_pkg::WORD_BITS-1:0] next_word = ws_new ? right_q : left_in; // RL6
	// the lsb of a short half lands on the slot where word select flips
	wire sdo_d = tx_more ? tx_sh_q[i2sap_pkg::WORD_BITS-1] : 1'b0; // RL15

	always_ff @(posedge CLOCK) begin
		if (!rst_n) begin
			right_q <= '0;
			cur_word_q <= '0;
			tx_sh_q <= '0;
			tx_cnt_q <= i2sap_pkg::TX_CNT_DONE;
			sdo_q <= 1'b0;
			underrun_q <= 1'b0;
		end else begin
			underrun_q <= load_left && !fifo_valid;
			if (load_left) begin
				right_q <= right_in;
			end
			if (fall) begin
				sdo_q <= sdo_d; // RL7
				if (trans) begin
					cur_word_q <= next_word; // RL4
					tx_sh_q <= next_word; // RL5
					tx_cnt_q <= '0;
				end else if (tx_more) begin
					tx_sh_q <= {tx_sh_q[i2sap_pkg::WORD_BITS-2:0], 1'b0};
					tx_cnt_q <= tx_cnt_q + 5'h01; // RL3
				end
			end
		end
	end

	// ==================================================================
	// receiver, sampled on the rising edge like any i2s receiver
	logic [i2sap_pkg::WORD_BITS-2:0] rx_sh_q;
	logic [4:0] rx_cnt_q;
	logic rx_ws_q;
	logic rx_ch_q;
	logic rx_valid_q;
	logic rx_right_q;
	logic [i2sap_pkg::WORD_BITS-1:0] rx_data_q;
	wire rx_ws_now = master_q ? ws_q : ws_in_q;
	wire rx_take = rise && (rx_cnt_q < i2sap_pkg::TX_CNT_DONE);
	wire rx_done = rx_take && (rx_cnt_q[3:0] == i2sap_pkg::RX_CNT_LAST);
	wire rx_trans = rise && (rx_ws_now != rx_ws_q);

	always_ff @(posedge CLOCK) begin
		if (!rst_n) begin
			rx_sh_q <= '0;
			rx_cnt_q <= i2sap_pkg::TX_CNT_DONE;
			rx_ws_q <= 1'b1;
			rx_ch_q <= 1'b1;
			rx_valid_q <= 1'b0;
			rx_right_q <= 1'b0;
			rx_data_q <= '0;
		end else begin
			rx_valid_q <= rx_done;
			if (rx_take) begin
				rx_sh_q <= {rx_sh_q[i2sap_pkg::WORD_BITS-3:0], SDI};
			end
			if (rx_done) begin
				rx_data_q <= {rx_sh_q, SDI}; // RL3
				rx_right_q <= rx_ch_q;
			end
			if (rx_trans) begin
				rx_ws_q <= rx_ws_now;
				rx_ch_q <= rx_ws_now; // RL6
				rx_cnt_q <= '0;
			end else if (rx_take) begin
				rx_cnt_q <= rx_cnt_q + 5'h01;
			end
		end
	end

	// ==================================================================
	// pins
	assign SCK_O = sck_q;
	assign SCK_OE = master_q; // RL1
	assign WS_O = ws_q;
	assign WS_OE = master_q; // RL1
	assign SDO = sdo_q; // RL2
	assign UNDERRUN = underrun_q;
	assign RX_VALID = rx_valid_q;
	assign RX_RIGHT = rx_right_q;
	assign RX_DATA = rx_data_q;

	// ==================================================================
	// checks
	logic [15:0] ph_cnt_q;
	logic [15:0] ph_prev_q;
	logic ph_seen_q;

	always_ff @(posedge CLOCK) begin
		if (!rst_n || !master_q) begin
			ph_cnt_q <= '0;
			ph_prev_q <= '0;
			ph_seen_q <= 1'b0;
		end else if (tick) begin
			ph_cnt_q <= '0;
			ph_prev_q <= ph_cnt_q;
			ph_seen_q <= 1'b1;
		end else begin
			ph_cnt_q <= ph_cnt_q + 16'h0001;
		end
	end

	sequence s_first_bit;
		fall && !trans && tx_cnt_q == 5'h00;
	endsequence

	sequence s_left_load;
		load_left && fifo_valid;
	endsequence

	property p_oe_mode;
		@(posedge CLOCK) disable iff (!rst_n)
		$past(rst_n) |-> SCK_OE == $past(MASTER) && WS_OE == $past(MASTER);
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("clock pin enables disagree with mode"); // RL1

	property p_sdo_fall;
		@(posedge CLOCK) disable iff (!rst_n)
		$changed(SDO) |-> $past(fall);
	endproperty
	a_sdo_fall: assert property (p_sdo_fall) else $error("data changed off a falling edge"); // RL7

	property p_msb_first;
		@(posedge CLOCK) disable iff (!rst_n)
		s_first_bit |=> SDO == cur_word_q[15];
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("msb not sent after word select"); // RL5

	property p_pad_low;
		@(posedge CLOCK) disable iff (!rst_n)
		fall && !tx_more |=> !SDO;
	endproperty
	a_pad_low: assert property (p_pad_low) else $error("spare slot not driven low"); // RL15

	property p_left_word;
		@(posedge CLOCK) disable iff (!rst_n)
		s_left_load |=> cur_word_q == $past(fifo_data[31:16]) && !ws_q;
	endproperty
	a_left_word: assert property (p_left_word) else $error("left word not in ws low half"); // RL4

	property p_frame_len;
		@(posedge CLOCK) disable iff (!rst_n)
		master_q && fall && fcnt_q == frame_last |=> fcnt_q == 6'h00 && !ws_q;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length wrong"); // RL9

	property p_mark_space;
		@(posedge CLOCK) disable iff (!rst_n)
		master_q && ph_seen_q && tick && ph_prev_q != 16'h0000 |->
			ph_cnt_q + 16'h0001 >= ph_prev_q && ph_cnt_q <= ph_prev_q + 16'h0001;
	endproperty
	a_mark_space: assert property (p_mark_space) else $error("bit clock phases unequal"); // RL12

	property p_rx_word;
		@(posedge CLOCK) disable iff (!rst_n)
		rx_done |=> RX_VALID ##1 !RX_VALID;
	endproperty
	a_rx_word: assert property (p_rx_word) else $error("received word pulse wrong"); // RL3
endmodule
`default_nettype wire

/* File: src/i2sap_pkg.sv */
// Purpose: shared constants of the stereo serial audio port
// Assumes: core clock of 100 MHz doubles as the divider reference clock
// Notes: divider defaults give the bit clock toggle rate (twice the bit rate)
package i2sap_pkg;
	// ==================================================================
	// clock and link rates
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned FRAME_HZ = 48_000;
	localparam int unsigned SLAVE_MAX_BCLK_HZ = 3_072_000;
	// least high or low phase at the fastest slave clock, 0.35 of its period
	localparam int unsigned SLAVE_MIN_PHASE_CYC =
		(CLK_HZ / 100 * 35 + SLAVE_MAX_BCLK_HZ - 1) / SLAVE_MAX_BCLK_HZ;

	// ==================================================================
	// frame layout
	localparam int unsigned WORD_BITS = 16;
	localparam int unsigned SLOTS_SHORT = 32;
	localparam int unsigned SLOTS_LONG = 50;
	localparam logic [5:0] HALF_SHORT = 6'h10;
	localparam logic [5:0] HALF_LONG = 6'h19;
	localparam logic [5:0] FRAME_SHORT_LAST = 6'h1f;
	localparam logic [5:0] FRAME_LONG_LAST = 6'h31;
	localparam logic [4:0] TX_CNT_DONE = 5'h10;
	localparam logic [3:0] RX_CNT_LAST = 4'hf;

	// ==================================================================
	// n/m divider: toggle rate = CLK_HZ * n / m
	localparam int unsigned DIV_W = 16;
	localparam logic [15:0] DIV_N_1536K = 16'h0060;
	localparam logic [15:0] DIV_M_1536K = 16'h0c35;
	localparam logic [15:0] DIV_N_2400K = 16'h0006;
	localparam logic [15:0] DIV_M_2400K = 16'h007d;

	// ==================================================================
	// sample buffer
	localparam int unsigned FIFO_WIDTH = 32;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam logic [1:0] RST_SYNC_INIT = 2'h0;
endpackage

/* File: src/i2sap_fifo.sv */
// Purpose: small synchronous fifo for stereo sample words
// Assumes: single clock, synchronous active low reset
// Notes: depth must be a power of two
`timescale 1ns/100ps
`default_nettype none
module i2sap_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// ==================================================================
	// pointers carry one extra bit so full and empty are told apart
	assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(push);
			rd_q <= rd_q + (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

/* File: test/i2sap_codec_model.sv */
// Purpose: codec model on the serial side of the audio port
// Assumes: called and sampled at the falling core clock edge
// Notes: slave clock stands low outside a played burst
`timescale 1ns/100ps
`default_nettype none
module i2sap_codec_model (
	input wire logic clk,
	input wire logic sck,
	input wire logic ws,
	input wire logic sdo,
	output logic sck_drv,
	output logic ws_drv,
	output logic sdi_drv
);
	logic sck_p = 1'b0;
	logic ws_q [$];
	logic bit_q [$];
	initial begin
		sck_drv = 1'b0;
		ws_drv = 1'b1;
		sdi_drv = 1'b0;
	end
	// ==================================================================
	// capture
	always @(negedge clk) begin
		if (sck && !sck_p) begin
			ws_q.push_back(ws);
			bit_q.push_back(sdo);
		end
		sck_p <= sck;
	end
	// ==================================================================
	// slave clock source, equal phases of hp core cycles
	task automatic play(input int hp, input logic [15:0] words [$]);
		logic prev;
		prev = 1'b0;
		for (int t = 0; t <= words.size() * 16; t++) begin
			sck_drv = 1'b0;
			if (t % 16 == 0)
				ws_drv = ((t / 16) % 2 == 1);
			sdi_drv = prev;
			if (t < words.size() * 16)
				prev = words[t / 16][15 - t % 16];
			repeat (hp) @(negedge clk);
			sck_drv = 1'b1;
			repeat (hp) @(negedge clk);
		end
		sck_drv = 1'b0;
		// released data line must not keep its last level
		sdi_drv = ~prev;
	endtask
endmodule
`default_nettype wire

/* File: test/tb_i2s_audio_port.sv */
// Purpose: self-checking bench of the stereo serial audio port
// Assumes: codec model on the serial pins, bench drives at falling edge
// Notes: fast divider keeps frames short except in the rate test
`timescale 1ns/100ps
`default_nettype none
module tb_i2s_audio_port;
	logic clk, rst_n, master, long_f, tx_valid;
	logic [15:0] div_n, div_m, rx_data;
	logic [31:0] tx_data;
	logic sck_o, sck_oe, ws_o, ws_oe, sdo, tx_ready, rx_valid, rx_right;
	logic sck_d, ws_d, sdi_d, run_ok, underrun;
	logic sck_p = 1'b0, sdo_p = 1'b0, ws_p = 1'b0;
	wire logic sck_w, ws_w;
	int fail_count = 0, num_checks = 0, edge_bad = 0, run = 0, cyc = 0;
	int hi_min, hi_max, lo_min, lo_max, fall_t, fall_p, underruns, ws_falls;
	logic [16:0] rx_q [$];
	assign sck_w = sck_oe ? sck_o : sck_d;
	assign ws_w = ws_oe ? ws_o : ws_d;
	i2sap_port dut (.CLOCK(clk), .RESETN(rst_n), .MASTER(master), .LONG_FRAME(long_f),
		.DIV_N(div_n), .DIV_M(div_m), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe),
		.WS_I(ws_w), .WS_O(ws_o), .WS_OE(ws_oe), .SDO(sdo), .SDI(sdi_d),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data), .UNDERRUN(underrun),
		.RX_VALID(rx_valid), .RX_RIGHT(rx_right), .RX_DATA(rx_data));
	i2sap_codec_model codec (.clk(clk), .sck(sck_w), .ws(ws_w), .sdo(sdo),
		.sck_drv(sck_d), .ws_drv(ws_d), .sdi_drv(sdi_d));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==================================================================
	// monitor
	always @(negedge clk) begin
		cyc <= cyc + 1;
		sck_p <= sck_o;
		sdo_p <= sdo;
		ws_p <= ws_o;
		run <= (sck_o !== sck_p) ? 1 : run + 1;
		if (rx_valid === 1'b1)
			rx_q.push_back({rx_right, rx_data});
		if (master && sdo !== sdo_p && !(sck_p && !sck_o))
			edge_bad <= edge_bad + 1;
		if (underrun === 1'b1)
			underruns <= underruns + 1;
		if (ws_p && !ws_o) begin
			ws_falls <= ws_falls + 1;
			fall_p <= fall_t;
			fall_t <= cyc;
		end
		// the phase cut by a stats clear is partial, so it is skipped
		if (sck_o !== sck_p)
			run_ok <= 1'b1;
		if (sck_o !== sck_p && run_ok && sck_p) begin
			hi_min <= (run < hi_min) ? run : hi_min;
			hi_max <= (run > hi_max) ? run : hi_max;
		end
		if (sck_o !== sck_p && run_ok && !sck_p) begin
			lo_min <= (run < lo_min) ? run : lo_min;
			lo_max <= (run > lo_max) ? run : lo_max;
		end
	end
	// ==================================================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic clear_stats();
		@(posedge clk);
		edge_bad = 0;
		underruns = 0;
		ws_falls = 0;
		run_ok = 1'b0;
		hi_min = 1000;
		lo_min = 1000;
		hi_max = 0;
		lo_max = 0;
		@(negedge clk);
	endtask
	task automatic do_reset(input logic lf, input logic [15:0] n, input logic [15:0] d);
		rst_n = 1'b0;
		master = 1'b0;
		long_f = lf;
		div_n = n;
		div_m = d;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		codec.ws_q.delete();
		codec.bit_q.delete();
		rx_q.delete();
	endtask
	task automatic check_stream(input int slots, input logic [15:0] exp [$]);
		int chg [$];
		logic [15:0] word;
		for (int i = 1; i < codec.ws_q.size(); i++)
			if (codec.ws_q[i] !== codec.ws_q[i-1])
				chg.push_back(i);
		check("halves", chg.size() > exp.size(), 1'b1);
		for (int k = 0; k < exp.size() && k + 1 < chg.size(); k++) begin
			for (int j = 0; j < 16; j++)
				word[15-j] = codec.bit_q[chg[k]+1+j];
			check("word", word, exp[k]);
			check("channel", codec.ws_q[chg[k]], k % 2);
			check("half", chg[k+1] - chg[k], slots / 2);
			for (int j = chg[k] + 17; j <= chg[k+1]; j++)
				check("pad", codec.bit_q[j], 1'b0);
		end
	endtask
	// ==================================================================
	// scenarios
	task automatic t_master_fifo();
		logic [31:0] w [$];
		logic [15:0] e [$];
		w = '{32'ha5c3_0f01, 32'h8000_7fff, 32'h1234_fedc, 32'h0001_ffff, 32'hdead_beef};
		for (int k = 0; k < 4; k++)
			e = {e, w[k][31:16], w[k][15:0]};
		e = {e, 16'h0000, 16'h0000};
		for (int lf = 0; lf < 2; lf++) begin
			do_reset(lf == 1, 16'h0001, 16'h0002);
			check("idle", {sck_oe, ws_oe, tx_ready}, 3'h1);
			tx_valid = 1'b1;
			foreach (w[k]) begin
				tx_data = w[k];
				@(negedge clk);
			end
			tx_valid = 1'b0;
			check("full", tx_ready, 1'b0);
			clear_stats();
			master = 1'b1;
			repeat (1500) @(negedge clk);
			check("oe", {sck_oe, ws_oe}, 2'h3);
			check("ready", tx_ready, 1'b1);
			// four stored words cover four frames, every later left start is silent
			check("underrun", underruns + 4 == ws_falls || underruns + 5 == ws_falls, 1'b1);
			check("edges", edge_bad, 0);
			check("phase", {hi_min[3:0], hi_max[3:0], lo_min[3:0], lo_max[3:0]}, 16'h2222);
			check_stream(lf ? 50 : 32, e);
		end
	endtask
	task automatic t_rates();
		for (int r = 0; r < 2; r++) begin
			do_reset(r == 1, r ? i2sap_pkg::DIV_N_2400K : i2sap_pkg::DIV_N_1536K,
				r ? i2sap_pkg::DIV_M_2400K : i2sap_pkg::DIV_M_1536K);
			master = 1'b1;
			repeat (2400) @(negedge clk);
			clear_stats();
			repeat (4400) @(negedge clk);
			// a frame is 2083 or 2084 cycles, both give the same third
			check("frame", (fall_t - fall_p) / 3, i2sap_pkg::CLK_HZ / i2sap_pkg::FRAME_HZ / 3);
			check("mark", hi_min * 100 >= 35 * (hi_max + lo_max), 1'b1);
			check("space", lo_min * 100 >= 35 * (hi_max + lo_max), 1'b1);
			check("edges", edge_bad, 0);
		end
	endtask
	task automatic t_slave();
		logic [15:0] s [$];
		s = '{16'ha5c3, 16'h8001, 16'h7ffe, 16'h1234};
		// 17 core cycles a phase is the fastest even clock under the slave limit
		for (int hp = 17; hp <= 32; hp += 15) begin
			do_reset(1'b0, 16'h0001, 16'h0002);
			codec.play(hp, s);
			repeat (8) @(negedge clk);
			check("slave oe", {sck_oe, ws_oe}, 2'h0);
			check("sdo", sdo === 1'b0 || sdo === 1'b1, 1'b1);
			check("rx count", rx_q.size() >= 4, 1'b1);
			for (int k = 0; k < 4 && rx_q.size() >= 4; k++)
				check("rx word", rx_q[rx_q.size() - 4 + k], {k % 2 == 1, s[k]});
		end
	endtask
	initial begin
		tx_valid = 1'b0;
		tx_data = 32'h0;
		t_master_fifo();
		t_rates();
		t_slave();
		stop_test();
	end
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
